// *** hw/rir_core.sv ***
// executes the software reset and return-from-interrupt instructions
`timescale 1ns/1ps
`include "rir_regs.svh"
module rir_core #(
    parameter int PC_W = 21 // program counter width
) (
    input wire logic sys_clk_i,                 // core clock, 250 MHz
    input wire logic rst_i,                     // async reset, active high
    input wire logic instr_valid_i,             // instruction word present
    input wire logic [15:0] instr_i,            // instruction word
    input wire logic [PC_W-1:0] stack_top_entry_i, // return stack top
    input wire logic pc_load_i,                 // sequencer pc update
    input wire logic [PC_W-1:0] pc_next_i,      // sequencer pc value
    input wire logic w_load_i,                  // datapath write of w
    input wire logic [7:0] w_data_i,            // datapath w value
    input wire logic status_load_i,             // datapath write of status
    input wire logic [7:0] status_data_i,       // datapath status value
    input wire logic bank_sel_load_i,           // datapath write of bank select
    input wire logic [3:0] bank_sel_data_i,     // datapath bank select value
    input wire logic pcu_load_i,                // write of upper pc latch
    input wire logic [4:0] pcu_data_i,          // upper pc latch value
    input wire logic pch_load_i,                // write of high pc latch
    input wire logic [7:0] pch_data_i,          // high pc latch value
    input wire logic shadow_save_i,             // interrupt entry saves shadows
    input wire logic int_enable_clear_i,        // interrupt entry clears enable
    input wire logic prio_low_i,                // returning from low priority
    input wire logic ipen_i,                    // priority levels enabled
    output logic stack_pop_o,                   // pop return stack, pulse
    output logic soft_reset_o,                  // software reset, pulse
    output logic busy_o,                        // idle second cycle
    output logic q_first_o,                     // decode quarter enable
    output logic [PC_W-1:0] pc_o,               // program counter
    output logic [7:0] w_o,                     // working register
    output logic [7:0] status_o,                // status register
    output logic [3:0] bank_select_reg_o,       // bank select register
    output logic [4:0] pc_upper_latch_o,        // upper pc latch
    output logic [7:0] pc_high_latch_o,         // high pc latch
    output logic high_prio_global_int_enable_o, // high priority enable
    output logic low_prio_global_int_enable_o   // low priority enable
);
    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    generate
        if (PC_W < 16 || PC_W > 32) begin : g_bad_pc
            $error("rir_core: PC_W must be 16 to 32");
        end
    endgenerate

    // ----------------------------------------
    // decode
    // ----------------------------------------
    rir_dec_if dec_bus ();

    rir_decode u_decode (
        .instr_i (instr_i),
        .dec (dec_bus.dec)
    );

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    rir_pkg::rir_state_t state, next_state;
    rir_pkg::rir_phase_t q, next_q;
    logic cur_reset, next_cur_reset;
    logic cur_ret_int, next_cur_ret_int;
    logic cur_shadow, next_cur_shadow;
    logic take;
    logic do_reset;
    logic do_pop;

    // take a word in the first quarter of a running cycle
    assign take = (state == rir_pkg::RIR_RUN) && (q == `RIR_Q_DECODE) && instr_valid_i;
    assign do_reset = cur_reset && (q == `RIR_Q_START_RESET);
    assign do_pop = cur_ret_int && (q == `RIR_Q_LAST);
    assign stack_pop_o = do_pop;
    assign soft_reset_o = do_reset;
    assign busy_o = (state == rir_pkg::RIR_IDLE_CYCLE);
    assign q_first_o = (q == `RIR_Q_DECODE);

    // next phase, state and latched decode
    always_comb begin
        next_q = q + 2'h1;
        next_state = state;
        next_cur_reset = cur_reset;
        next_cur_ret_int = cur_ret_int;
        next_cur_shadow = cur_shadow;
        if (take) begin
            next_cur_reset = dec_bus.is_reset;
            next_cur_ret_int = dec_bus.is_ret_int;
            next_cur_shadow = dec_bus.shadow_sel;
        end
        if (q == `RIR_Q_LAST) begin
            next_cur_reset = 1'b0;
            next_cur_ret_int = 1'b0;
            case (state)
                rir_pkg::RIR_RUN: begin
                    if (cur_ret_int) begin
                        next_state = rir_pkg::RIR_IDLE_CYCLE;
                    end
                end
                rir_pkg::RIR_IDLE_CYCLE: begin
                    next_state = rir_pkg::RIR_RUN;
                end
                default: begin
                    next_state = rir_pkg::RIR_RUN;
                end
            endcase
        end
    end

    // register sequencing state
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= `RIR_Q_DECODE;
            state <= rir_pkg::RIR_RUN;
            cur_reset <= 1'b0;
            cur_ret_int <= 1'b0;
            cur_shadow <= 1'b0;
        end else begin
            q <= next_q;
            state <= next_state;
            cur_reset <= next_cur_reset;
            cur_ret_int <= next_cur_ret_int;
            cur_shadow <= next_cur_shadow;
        end
    end

    // ----------------------------------------
    // architectural registers
    // ----------------------------------------
    logic [PC_W-1:0] pc, next_pc;
    logic [7:0] w, next_w, shadow_w, next_shadow_w;
    logic [7:0] status, next_status, shadow_status, next_shadow_status;
    logic [3:0] bank_sel, next_bank_sel, shadow_bank, next_shadow_bank;
    logic [4:0] pcu, next_pcu;
    logic [7:0] pch, next_pch;
    logic en_hi, next_en_hi, en_lo, next_en_lo;

    // datapath writes first, then instruction effects override
    always_comb begin
        next_pc = pc_load_i ? pc_next_i : pc;
        next_w = w_load_i ? w_data_i : w;
        next_status = status_load_i ? status_data_i : status;
        next_bank_sel = bank_sel_load_i ? bank_sel_data_i : bank_sel;
        next_pcu = pcu_load_i ? pcu_data_i : pcu;
        next_pch = pch_load_i ? pch_data_i : pch;
        next_shadow_w = shadow_save_i ? next_w : shadow_w;
        next_shadow_status = shadow_save_i ? next_status : shadow_status;
        next_shadow_bank = shadow_save_i ? next_bank_sel : shadow_bank;
        next_en_hi = int_enable_clear_i ? 1'b0 : en_hi;
        next_en_lo = int_enable_clear_i ? 1'b0 : en_lo;
        if (do_pop) begin
            next_pc = stack_top_entry_i;
            next_pcu = pcu;
            next_pch = pch;
            // set wins over a same-cycle enable clear
            if (ipen_i && prio_low_i) begin
                next_en_lo = 1'b1;
            end else begin
                next_en_hi = 1'b1;
            end
            if (cur_shadow) begin
                next_w = shadow_w;
                next_status = shadow_status;
                next_bank_sel = shadow_bank;
            end
        end
        if (do_reset) begin
            next_pc = '0;
            next_w = `RIR_W_RST;
            next_status = `RIR_STATUS_RST;
            next_bank_sel = `RIR_BANK_RST;
            next_shadow_w = `RIR_W_RST;
            next_shadow_status = `RIR_STATUS_RST;
            next_shadow_bank = `RIR_BANK_RST;
            next_pcu = `RIR_PCU_RST;
            next_pch = `RIR_PCH_RST;
            next_en_hi = `RIR_INT_EN_RST;
            next_en_lo = `RIR_INT_EN_RST;
        end
    end

    // register architectural state
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc <= '0;
            w <= `RIR_W_RST;
            status <= `RIR_STATUS_RST;
            bank_sel <= `RIR_BANK_RST;
            shadow_w <= `RIR_W_RST;
            shadow_status <= `RIR_STATUS_RST;
            shadow_bank <= `RIR_BANK_RST;
            pcu <= `RIR_PCU_RST;
            pch <= `RIR_PCH_RST;
            en_hi <= `RIR_INT_EN_RST;
            en_lo <= `RIR_INT_EN_RST;
        end else begin
            pc <= next_pc;
            w <= next_w;
            status <= next_status;
            bank_sel <= next_bank_sel;
            shadow_w <= next_shadow_w;
            shadow_status <= next_shadow_status;
            shadow_bank <= next_shadow_bank;
            pcu <= next_pcu;
            pch <= next_pch;
            en_hi <= next_en_hi;
            en_lo <= next_en_lo;
        end
    end

    // drive outputs from flops
    assign pc_o = pc;
    assign w_o = w;
    assign status_o = status;
    assign bank_select_reg_o = bank_sel;
    assign pc_upper_latch_o = pcu;
    assign pc_high_latch_o = pch;
    assign high_prio_global_int_enable_o = en_hi;
    assign low_prio_global_int_enable_o = en_lo;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_reset_clears_regs: assert property (soft_reset_o |=> (w_o == `RIR_W_RST && status_o == `RIR_STATUS_RST
        && pc_o == '0 && !high_prio_global_int_enable_o && pc_high_latch_o == `RIR_PCH_RST))
        else $error("software reset did not restore reset values");
    a_pop_loads_pc: assert property (stack_pop_o |=> pc_o == $past(stack_top_entry_i))
        else $error("pc not loaded from stack top");
    a_return_sets_enable: assert property (stack_pop_o && !soft_reset_o |=>
        (high_prio_global_int_enable_o || low_prio_global_int_enable_o))
        else $error("global enable not set on return");
    a_shadow_restore: assert property (stack_pop_o && cur_shadow |=>
        (w_o == $past(shadow_w) && status_o == $past(shadow_status) && bank_select_reg_o == $past(shadow_bank)))
        else $error("shadow copies not restored");
    a_no_shadow_keep: assert property (stack_pop_o && !cur_shadow && !w_load_i && !status_load_i
        && !bank_sel_load_i |=> ($stable(w_o) && $stable(status_o) && $stable(bank_select_reg_o)))
        else $error("live registers changed without shadow select");
    a_latch_kept: assert property (stack_pop_o |=> ($stable(pc_upper_latch_o) && $stable(pc_high_latch_o)))
        else $error("pc latches changed on return");
    a_return_two_cycles: assert property (stack_pop_o |=> busy_o [*4] ##1 !busy_o)
        else $error("return did not take exactly one idle cycle");
    a_pop_fourth_quarter: assert property (stack_pop_o |-> q == `RIR_Q_LAST && !busy_o)
        else $error("pop outside fourth quarter");
    a_reset_one_cycle: assert property (soft_reset_o |-> ##2 !busy_o ##1 (q_first_o && !busy_o))
        else $error("software reset not single cycle");
endmodule

// *** include/rir_regs.svh ***
// opcodes, reset values and phase counts for the reset and return-from-interrupt unit
`ifndef RIR_REGS_SVH
`define RIR_REGS_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define RIR_OP_RESET 16'h00ff
`define RIR_OP_RET_INT 16'h0010
`define RIR_OP_RET_INT_MASK 16'hfffe
`define RIR_SHADOW_BIT 0

// ----------------------------------------
// master-clear reset values
// ----------------------------------------
`define RIR_W_RST 8'h00
`define RIR_STATUS_RST 8'h00
`define RIR_BANK_RST 4'h0
`define RIR_PCU_RST 5'h00
`define RIR_PCH_RST 8'h00
`define RIR_INT_EN_RST 1'b0

// ----------------------------------------
// quarter-cycle phases
// ----------------------------------------
`define RIR_Q_DECODE 2'h0
`define RIR_Q_START_RESET 2'h1
`define RIR_Q_LAST 2'h3

`endif

// *** include/rir_pkg.sv ***
// types shared by the reset and return-from-interrupt unit
package rir_pkg;
    // instruction-cycle sequencing
    typedef enum logic [0:0] {
        RIR_RUN,
        RIR_IDLE_CYCLE
    } rir_state_t;

    // quarter-cycle phase counter
    typedef logic [1:0] rir_phase_t;
endpackage

// *** include/rir_dec_if.sv ***
// decode results passed from the opcode decoder to the core
`timescale 1ns/1ps
interface rir_dec_if;
    logic is_reset;   // software reset opcode
    logic is_ret_int; // return from interrupt opcode
    logic shadow_sel; // restore shadow copies
    modport dec (output is_reset, output is_ret_int, output shadow_sel);
    modport core (input is_reset, input is_ret_int, input shadow_sel);
endinterface

// *** hw/rir_decode.sv ***
// opcode decoder for software reset and return from interrupt
`timescale 1ns/1ps
`include "rir_regs.svh"
module rir_decode (
    input wire logic [15:0] instr_i, // fetched instruction word
    rir_dec_if.dec dec               // decode results
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic logic match_ret_int(input logic [15:0] op);
        match_ret_int = (op & `RIR_OP_RET_INT_MASK) == `RIR_OP_RET_INT;
    endfunction

    // classify the word
    assign dec.is_reset = (instr_i == `RIR_OP_RESET);
    assign dec.is_ret_int = match_ret_int(instr_i);
    assign dec.shadow_sel = match_ret_int(instr_i) & instr_i[`RIR_SHADOW_BIT];
endmodule

// *** verif/rir_stack_model.sv ***
// behavioural return stack standing in for the core sequencer side
`timescale 1ns/1ps
module rir_stack_model #(
    parameter int PC_W = 21 // return address width
) (
    input wire logic sys_clk_i, // core clock
    input wire logic rst_i, // async reset, active high
    input wire logic push_i, // push a return address
    input wire logic [PC_W-1:0] push_data_i, // address to push
    input wire logic pop_i, // pop request from the unit
    output logic [PC_W-1:0] stack_top_entry_o // current top of stack
);
    logic [PC_W-1:0] mem [0:7];
    logic [2:0] depth;
    logic [PC_W-1:0] last;
    // push and pop; an empty stack shows the inverse of the last popped value
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            depth <= 3'h0;
            last <= '0;
        end else if (push_i) begin
            mem[depth] <= push_data_i;
            depth <= depth + 3'h1;
        end else if (pop_i && depth != 3'h0) begin
            last <= mem[depth - 3'h1];
            depth <= depth - 3'h1;
        end
    end
    assign stack_top_entry_o = (depth != 3'h0) ? mem[depth - 3'h1] : ~last;
endmodule

// *** verif/testbench.sv ***
// self-checking bench for the reset and return-from-interrupt unit
`timescale 1ns/1ps
`include "rir_regs.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin num_errors++; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module testbench;
    localparam int PCW = 21;
    typedef struct {int take; bit rst; logic [PCW-1:0] pc; logic [7:0] w, st, pch; logic [3:0] b; logic [4:0] pcu; logic hi, lo;} rir_note_t;
    logic sys_clk_i, rst_i, instr_valid_i, pc_load_i, w_load_i, status_load_i, bank_sel_load_i, pcu_load_i, pch_load_i;
    logic shadow_save_i, int_enable_clear_i, prio_low_i, ipen_i, push_i, stack_pop_o, soft_reset_o, busy_o, q_first_o;
    logic high_prio_global_int_enable_o, low_prio_global_int_enable_o;
    logic [15:0] instr_i;
    logic [PCW-1:0] stack_top_entry_i, pc_next_i, push_data_i, pc_o, m_pc;
    logic [7:0] w_data_i, status_data_i, pch_data_i, w_o, status_o, pc_high_latch_o, m_w, m_st, m_pch, m_sw, m_ss;
    logic [3:0] bank_sel_data_i, bank_select_reg_o, m_b, m_sb;
    logic [4:0] pcu_data_i, pc_upper_latch_o, m_pcu;
    logic m_hi, m_lo;
    int num_errors, checks_done, cyc, i;
    rir_note_t notes[$];
    logic [PCW-1:0] stk[$];

    rir_core #(.PC_W(PCW)) rir_core_inst (.sys_clk_i, .rst_i, .instr_valid_i, .instr_i, .stack_top_entry_i, .pc_load_i,
        .pc_next_i, .w_load_i, .w_data_i, .status_load_i, .status_data_i, .bank_sel_load_i, .bank_sel_data_i,
        .pcu_load_i, .pcu_data_i, .pch_load_i, .pch_data_i, .shadow_save_i, .int_enable_clear_i, .prio_low_i, .ipen_i,
        .stack_pop_o,
        .soft_reset_o, .busy_o, .q_first_o, .pc_o, .w_o, .status_o, .bank_select_reg_o, .pc_upper_latch_o,
        .pc_high_latch_o, .high_prio_global_int_enable_o, .low_prio_global_int_enable_o);
    rir_stack_model #(.PC_W(PCW)) rir_stack_model_inst (.sys_clk_i, .rst_i, .push_i, .push_data_i,
        .pop_i(stack_pop_o), .stack_top_entry_o(stack_top_entry_i));

    // ----------------------------------------
    // clock, cycle count, closing report
    // ----------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) cyc <= cyc + 1;
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // driver tasks
    // ----------------------------------------
    // random datapath and latch writes, optional shadow save and enable clear
    task automatic dp(input bit save, input bit clr);
        @(posedge sys_clk_i);
        m_w = 8'($urandom());
        m_st = 8'($urandom());
        m_b = 4'($urandom());
        m_pcu = 5'($urandom());
        m_pch = 8'($urandom());
        m_pc = PCW'($urandom());
        if (save) {m_sw, m_ss, m_sb} = {m_w, m_st, m_b};
        if (clr) {m_hi, m_lo} = 2'h0;
        {w_load_i, status_load_i, bank_sel_load_i, pcu_load_i, pch_load_i, pc_load_i} <= 6'h3f;
        {w_data_i, status_data_i, bank_sel_data_i, pcu_data_i, pch_data_i, pc_next_i} <=
            {m_w, m_st, m_b, m_pcu, m_pch, m_pc};
        {shadow_save_i, int_enable_clear_i} <= {save, clr};
        @(posedge sys_clk_i);
        {w_load_i, status_load_i, bank_sel_load_i, pcu_load_i, pch_load_i, pc_load_i} <= 6'h00;
        {shadow_save_i, int_enable_clear_i} <= 2'h0;
    endtask
    task automatic push(input logic [PCW-1:0] v);
        @(posedge sys_clk_i);
        push_i <= 1'b1;
        push_data_i <= v;
        stk.push_back(v);
        @(posedge sys_clk_i);
        push_i <= 1'b0;
    endtask
    // hold the word until a decode quarter takes it, noting the expected outcome
    task automatic issue(input logic [15:0] op);
        rir_note_t n;
        int k;
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= op;
        for (k = 0; k < 40; k++) begin
            @(negedge sys_clk_i);
            if (q_first_o === 1'b1 && busy_o === 1'b0) break;
        end
        if (k == 40) begin num_errors++; summarize(); end
        if (op == `RIR_OP_RESET) begin
            {m_pc, m_w, m_st, m_b, m_pcu, m_pch, m_hi, m_lo, m_sw, m_ss, m_sb} = '0;
        end else if ((op & `RIR_OP_RET_INT_MASK) == `RIR_OP_RET_INT) begin
            m_pc = stk.pop_back();
            if (ipen_i && prio_low_i) m_lo = 1'b1;
            else m_hi = 1'b1;
            if (op[`RIR_SHADOW_BIT]) {m_w, m_st, m_b} = {m_sw, m_ss, m_sb};
        end
        n = '{cyc, op == `RIR_OP_RESET, m_pc, m_w, m_st, m_pch, m_b, m_pcu, m_hi, m_lo};
        if (op == `RIR_OP_RESET || (op & `RIR_OP_RET_INT_MASK) == `RIR_OP_RET_INT) notes.push_back(n);
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b0;
        // a latch write landing on the pop edge must be dropped
        if ((op & `RIR_OP_RET_INT_MASK) == `RIR_OP_RET_INT) begin
            repeat (2) @(posedge sys_clk_i);
            {pcu_load_i, pch_load_i} <= 2'h3;
            {pcu_data_i, pch_data_i} <= 13'($urandom());
            @(posedge sys_clk_i);
            {pcu_load_i, pch_load_i} <= 2'h0;
        end
    endtask
    task automatic settle(input string nm);
        int k;
        for (k = 0; k < 50 && notes.size() != 0; k++) @(posedge sys_clk_i);
        if (notes.size() != 0) begin num_errors++; summarize(); end
        repeat (6) @(posedge sys_clk_i);
        $display("test %s done", nm);
    endtask

    // ----------------------------------------
    // monitor: each pulse takes the oldest note
    // ----------------------------------------
    initial begin
        rir_note_t n;
        forever begin
            @(negedge sys_clk_i);
            if (rst_i === 1'b0 && (stack_pop_o === 1'b1 || soft_reset_o === 1'b1)) begin
                `CHK("pending note", 1'b1, notes.size() != 0)
                if (notes.size() == 0) continue;
                n = notes.pop_front();
                `CHK("reset pulse", n.rst, soft_reset_o)
                `CHK("answer delay", n.rst ? 1 : 3, cyc - n.take)
                @(negedge sys_clk_i);
                `CHK("pulse width", 1'b0, stack_pop_o | soft_reset_o)
                `CHK("busy", !n.rst, busy_o)
                `CHK("decode quarter", !n.rst, q_first_o)
                `CHK("pc", n.pc, pc_o)
                `CHK("w", n.w, w_o)
                `CHK("status", n.st, status_o)
                `CHK("bank select", n.b, bank_select_reg_o)
                `CHK("pc upper latch", n.pcu, pc_upper_latch_o)
                `CHK("pc high latch", n.pch, pc_high_latch_o)
                `CHK("high enable", n.hi, high_prio_global_int_enable_o)
                `CHK("low enable", n.lo, low_prio_global_int_enable_o)
            end
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_i, instr_valid_i, pc_load_i, w_load_i, status_load_i, bank_sel_load_i, pcu_load_i, pch_load_i} = 8'h80;
        {shadow_save_i, int_enable_clear_i, prio_low_i, ipen_i, push_i, instr_i} = '0;
        {pc_next_i, push_data_i, w_data_i, status_data_i, pch_data_i, bank_sel_data_i, pcu_data_i} = '0;
        {m_pc, m_w, m_st, m_b, m_pcu, m_pch, m_hi, m_lo, m_sw, m_ss, m_sb} = '0;
        {num_errors, checks_done, cyc} = '0;
        void'($urandom(91025));
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        dp(1'b1, 1'b1);
        dp(1'b0, 1'b0);
        push(PCW'($urandom()));
        issue(`RIR_OP_RET_INT | 16'h0001);
        settle("shadow_restore");
        {ipen_i, prio_low_i} <= 2'h3;
        dp(1'b1, 1'b1);
        dp(1'b0, 1'b0);
        push(PCW'($urandom()));
        issue(`RIR_OP_RET_INT);
        settle("low_priority_no_restore");
        // second return and reset are offered while busy and must wait
        dp(1'b1, 1'b1);
        push(PCW'($urandom()));
        push(PCW'($urandom()));
        issue(`RIR_OP_RET_INT | 16'h0001);
        issue(`RIR_OP_RET_INT);
        issue(`RIR_OP_RESET);
        settle("back_to_back_then_reset");
        issue(16'h0012);
        issue(16'h0006);
        issue(16'h00fe);
        settle("other_opcodes_ignored");
        for (i = 0; i < 8; i++) begin
            {ipen_i, prio_low_i} <= 2'($urandom());
            dp(1'($urandom()), 1'b1);
            dp(1'b0, 1'b0);
            push(PCW'($urandom()));
            issue(`RIR_OP_RET_INT | 16'($urandom() & 1));
            settle("random_return");
        end
        dp(1'b1, 1'b0);
        issue(`RIR_OP_RESET);
        settle("soft_reset");
        summarize();
    end
endmodule
